/* File: rtl/rvm_regs.sv */
// Voltage code and buck mode/disable register bank of the power manager.
// Assumes a byte-wide register port driven by the two-wire slave on mclk.
`timescale 1ns/1ps
`default_nettype none
module rvm_regs
	import rvm_pkg::*;
#(
	parameter int ENABLE_PINS = 6
)
(
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      arst_n,
	// Register port
	input  wire logic [7:0]                reg_addr,
	input  wire logic                      reg_wr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	output logic                           reg_hit,
	// Enable pins and rail assignment
	input  wire logic [ENABLE_PINS-1:0]    rail_enable_control_pins,
	input  wire logic [2:0][2:0]           buck_pin_select,
	input  wire logic                      buck_six_step_select,
	// Regulator controls
	output logic      [6:0]                buck_six_sleep_voltage_code,
	output rvm_pkg::rvm_step_e             buck_six_step_table,
	output logic      [3:0]                ldo_two_sleep_voltage_code,
	output logic      [3:0]                ldo_two_normal_voltage_code,
	output logic      [3:0]                ldo_three_sleep_voltage_code,
	output logic      [3:0]                ldo_three_normal_voltage_code,
	output logic                           buck_one_mode_select,
	output logic                           buck_two_mode_select,
	output logic                           buck_three_mode_select,
	output logic      [2:0]                buck_run
);
	import rvm_pkg::*;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	generate
		if (ENABLE_PINS < 1 || ENABLE_PINS > 8)
		begin : g_bad
			$error("ENABLE_PINS must be 1 to 8");
		end
	endgenerate

	logic [7:0]             b6_q;
	logic [7:0]             ldo2_q;
	logic [7:0]             ldo3_q;
	logic [5:0]             ctrl_q;
	logic [ENABLE_PINS-1:0] pin_lvl;
	logic                   wr_b6;
	logic                   wr_ldo2;
	logic                   wr_ldo3;
	logic                   wr_ctrl;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < ENABLE_PINS; gi++)
		begin : g_sync
			rvm_sync u_sync
			(
				.mclk      (mclk),
				.arst_n    (arst_n),
				.pin_in    (rail_enable_control_pins[gi]),
				.level_out (pin_lvl[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	always_comb
	begin
		wr_b6   = 1'b0;
		wr_ldo2 = 1'b0;
		wr_ldo3 = 1'b0;
		wr_ctrl = 1'b0;
		reg_hit = 1'b1;
		if (reg_addr == ADDR_BUCK_SIX_SLEEP_VOLTAGE)
			wr_b6 = reg_wr;
		else if (reg_addr == ADDR_LDO_TWO_VOLTAGE)
			wr_ldo2 = reg_wr;
		else if (reg_addr == ADDR_LDO_THREE_VOLTAGE)
			wr_ldo3 = reg_wr;
		else if (reg_addr == ADDR_BUCK_ONE_TO_THREE_CONTROL)
			wr_ctrl = reg_wr;
		else
			reg_hit = 1'b0;
	end

	// ------------------------------------------------------------
	// Voltage code registers
	// ------------------------------------------------------------
	// Buck six sleep code; bit 0 never stored so it reads zero
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			b6_q <= RST_BUCK_SIX_SLEEP;
		else if (wr_b6)
			b6_q <= reg_wdata & MASK_BUCK_SIX_SLEEP;
	end

	// LDO two sleep and normal codes
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			ldo2_q <= RST_LDO_TWO;
		else if (wr_ldo2)
			ldo2_q <= reg_wdata;
	end

	// LDO three sleep and normal codes
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			ldo3_q <= RST_LDO_THREE;
		else if (wr_ldo3)
			ldo3_q <= reg_wdata;
	end

	// ------------------------------------------------------------
	// Buck control register
	// ------------------------------------------------------------
	// Bits 7:6 are not stored; a reserved mode write of 0 is kept as written,
	// since the host is the one bound not to write it
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			ctrl_q <= RST_BUCK_CTRL;
		else if (wr_ctrl)
			ctrl_q <= reg_wdata[5:0];
	end

	// ------------------------------------------------------------
	// Read data, registered
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			if (reg_addr == ADDR_BUCK_SIX_SLEEP_VOLTAGE)
				reg_rdata <= b6_q & MASK_BUCK_SIX_SLEEP;
			else if (reg_addr == ADDR_LDO_TWO_VOLTAGE)
				reg_rdata <= ldo2_q;
			else if (reg_addr == ADDR_LDO_THREE_VOLTAGE)
				reg_rdata <= ldo3_q;
			else if (reg_addr == ADDR_BUCK_ONE_TO_THREE_CONTROL)
				reg_rdata <= {2'b00, ctrl_q} & MASK_BUCK_CTRL;
			else
				reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Field outputs
	// ------------------------------------------------------------
	assign buck_six_sleep_voltage_code   = b6_q[B6_CODE_MSB:B6_CODE_LSB];
	assign ldo_two_sleep_voltage_code    = ldo2_q[LDO_SLEEP_MSB:LDO_SLEEP_LSB];
	assign ldo_two_normal_voltage_code   = ldo2_q[LDO_NORMAL_MSB:LDO_NORMAL_LSB];
	assign ldo_three_sleep_voltage_code  = ldo3_q[LDO_SLEEP_MSB:LDO_SLEEP_LSB];
	assign ldo_three_normal_voltage_code = ldo3_q[LDO_NORMAL_MSB:LDO_NORMAL_LSB];
	assign buck_three_mode_select        = ctrl_q[MODE_THREE_BIT];
	assign buck_two_mode_select          = ctrl_q[MODE_TWO_BIT];
	assign buck_one_mode_select          = ctrl_q[MODE_ONE_BIT];

	// Step table choice for the buck six code
	assign buck_six_step_table = buck_six_step_select ? RVM_STEP_25MV : RVM_STEP_10MV;

	// ------------------------------------------------------------
	// Buck run gating
	// ------------------------------------------------------------
	// Soft disable overrides the assigned pin; releasing it hands control
	// straight back to the pin with no stored state to clear
	logic [2:0] pin_req;
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (int'(buck_pin_select[i]) < ENABLE_PINS)
				pin_req[i] = pin_lvl[buck_pin_select[i]];
			else
				pin_req[i] = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			buck_run <= 3'b000;
		else
		begin
			buck_run[0] <= pin_req[0] & ctrl_q[DIS_ONE_BIT];
			buck_run[1] <= pin_req[1] & ctrl_q[DIS_TWO_BIT];
			buck_run[2] <= pin_req[2] & ctrl_q[DIS_THREE_BIT];
		end
	end

endmodule
`default_nettype wire

/* File: rtl/rvm_pkg.sv */
// Package for the regulator voltage and mode register bank.
// Assumes a byte-wide register port from the two-wire management slave.
package rvm_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_BUCK_SIX_SLEEP_VOLTAGE    = 8'h99;
	localparam logic [7:0] ADDR_LDO_TWO_VOLTAGE           = 8'h9A;
	localparam logic [7:0] ADDR_LDO_THREE_VOLTAGE         = 8'h9B;
	localparam logic [7:0] ADDR_BUCK_ONE_TO_THREE_CONTROL = 8'h9C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int B6_CODE_LSB    = 1;
	localparam int B6_CODE_MSB    = 7;
	localparam int LDO_SLEEP_LSB  = 4;
	localparam int LDO_SLEEP_MSB  = 7;
	localparam int LDO_NORMAL_LSB = 0;
	localparam int LDO_NORMAL_MSB = 3;
	localparam int MODE_ONE_BIT   = 3;
	localparam int MODE_TWO_BIT   = 4;
	localparam int MODE_THREE_BIT = 5;
	localparam int DIS_ONE_BIT    = 0;
	localparam int DIS_TWO_BIT    = 1;
	localparam int DIS_THREE_BIT  = 2;

	// ------------------------------------------------------------
	// Reset values (stand-ins for the one-time-programmable defaults)
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BUCK_SIX_SLEEP = 8'h00;
	localparam logic [7:0] RST_LDO_TWO        = 8'h00;
	localparam logic [7:0] RST_LDO_THREE      = 8'h00;
	localparam logic [5:0] RST_BUCK_CTRL      = 6'h3F;

	// Readable masks: reserved bits read zero
	localparam logic [7:0] MASK_BUCK_SIX_SLEEP = 8'hFE;
	localparam logic [7:0] MASK_BUCK_CTRL      = 8'h3F;

	// Buck six step table selection
	typedef enum logic [1:0] {
		RVM_STEP_10MV = 2'b01,
		RVM_STEP_25MV = 2'b10
	} rvm_step_e;

endpackage

/* File: rtl/rvm_sync.sv */
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes pin input asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module rvm_sync
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// Level
	input  wire logic pin_in,
	output logic      level_out
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// ------------------------------------------------------------
	// Sync chain
	// ------------------------------------------------------------
	// First stage feeds only the second
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change counts once stages two and three agree
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			level_out <= 1'b0;
		else if (s2_q == s3_q)
			level_out <= s3_q;
	end

endmodule
`default_nettype wire

/* File: sim/rvm_regs_assertions.sv */
// Port checks for the regulator voltage and mode register bank.
// Assumes one mclk domain; bound into every rvm_regs instance.
`timescale 1ns/1ps
`default_nettype none
module rvm_regs_chk
	import rvm_pkg::*;
(
	// Clock, reset and register port
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Regulator controls
	input wire logic       buck_six_step_select,
	input wire logic [6:0] buck_six_sleep_voltage_code,
	input wire logic [1:0] buck_six_step_table,
	input wire logic [3:0] ldo_two_sleep_voltage_code,
	input wire logic [3:0] ldo_two_normal_voltage_code,
	input wire logic [3:0] ldo_three_sleep_voltage_code,
	input wire logic [3:0] ldo_three_normal_voltage_code,
	input wire logic       buck_one_mode_select,
	input wire logic       buck_two_mode_select,
	input wire logic       buck_three_mode_select,
	input wire logic [2:0] buck_run
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_b6; reg_wr && reg_addr == 8'h99
		|=> buck_six_sleep_voltage_code == $past(reg_wdata[7:1]); endproperty
	a_b6: assert property (p_b6) else $error("buck six code mismatch");
	property p_step; buck_six_step_table ==
		(buck_six_step_select ? RVM_STEP_25MV : RVM_STEP_10MV); endproperty
	a_step: assert property (p_step) else $error("step table mismatch");
	property p_l2; reg_wr && reg_addr == 8'h9A |=> {ldo_two_sleep_voltage_code,
		ldo_two_normal_voltage_code} == $past(reg_wdata); endproperty
	a_l2: assert property (p_l2) else $error("ldo two codes mismatch");
	property p_l3; reg_wr && reg_addr == 8'h9B |=> {ldo_three_sleep_voltage_code,
		ldo_three_normal_voltage_code} == $past(reg_wdata); endproperty
	a_l3: assert property (p_l3) else $error("ldo three codes mismatch");
	property p_mode; reg_wr && reg_addr == 8'h9C |=> {buck_three_mode_select,
		buck_two_mode_select, buck_one_mode_select} == $past(reg_wdata[5:3]); endproperty
	a_mode: assert property (p_mode) else $error("mode bits mismatch");
	// Disable must win over any pin level once the write has landed
	property p_off; reg_wr && reg_addr == 8'h9C ##1 !(reg_wr && reg_addr == 8'h9C)
		|=> (buck_run & ~$past(reg_wdata[2:0], 2)) == 3'b000; endproperty
	a_off: assert property (p_off) else $error("buck ran while disabled");
	property p_rsv; reg_rd && (reg_addr == 8'h99 || reg_addr == 8'h9C) |=> (reg_rdata &
		~($past(reg_addr) == 8'h99 ? MASK_BUCK_SIX_SLEEP : MASK_BUCK_CTRL)) == 8'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
	property p_rd; reg_rd && !reg_wr && reg_addr == 8'h9B |=> reg_rdata ==
		{ldo_three_sleep_voltage_code, ldo_three_normal_voltage_code}; endproperty
	a_rd: assert property (p_rd) else $error("read data mismatch");
	// Main scenarios
	c_off: cover property (reg_wr && reg_addr == 8'h9C && !reg_wdata[0]);
	c_on: cover property ($rose(buck_run[0]));
	c_25: cover property (buck_six_step_select);
endmodule
bind rvm_regs rvm_regs_chk u_chk (.mclk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
	.reg_rdata, .buck_six_step_select, .buck_six_sleep_voltage_code, .buck_six_step_table,
	.ldo_two_sleep_voltage_code, .ldo_two_normal_voltage_code, .ldo_three_sleep_voltage_code,
	.ldo_three_normal_voltage_code, .buck_one_mode_select, .buck_two_mode_select,
	.buck_three_mode_select, .buck_run);
`default_nettype wire

/* File: sim/rvm_host.sv */
// Host model on the register port of the power manager.
// Assumes requests launched at the falling edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module rvm_host
(
	// Clock and read data
	input  wire logic       mclk,
	input  wire logic [7:0] reg_rdata,
	// Register port
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd
);
	// Idle bus from time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// One-cycle write; mode three is never written as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = (a == 8'h9C) ? (d | 8'h20) : d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata; // Released data shows no stale value
	end
	endtask
	// One-cycle read, data taken a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
	begin
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		d = reg_rdata;
	end
	endtask
endmodule
`default_nettype wire

/* File: sim/regulator_voltage_mode_regs_test.sv */
// Self-checking bench for the register bank against a byte model.
// Assumes random pin levels, pin-to-buck assignment and step choice.
`timescale 1ns/1ps
`default_nettype none
module regulator_voltage_mode_regs_test;
	import rvm_pkg::*;
	logic       mclk = 1'b0;
	logic       arst_n = 1'b0;
	logic       step_sel = 1'b0;
	logic [5:0] pins = 6'h00;
	logic [2:0][2:0] psel = {3'd2, 3'd1, 3'd0};
	logic [6:0] b6;
	logic [3:0] l2s, l2n, l3s, l3n;
	logic [2:0] md, run;
	logic [7:0] addr, wdata, rdata, a, d;
	logic       wr, rd, hit;
	rvm_step_e  tab;
	logic [31:0] seed = 32'h0000864F;
	int m [4] = '{0, 0, 0, 'h3F};
	int error_cnt = 0;
	int check_count = 0;
	// ----------------------------------------
	// Clock, host and device
	// ----------------------------------------
	always #2.5 mclk = ~mclk;
	rvm_host h (.mclk(mclk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rd(rd));
	rvm_regs dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(addr), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .reg_hit(hit),
		.rail_enable_control_pins(pins), .buck_pin_select(psel),
		.buck_six_step_select(step_sel), .buck_six_sleep_voltage_code(b6),
		.buck_six_step_table(tab), .ldo_two_sleep_voltage_code(l2s),
		.ldo_two_normal_voltage_code(l2n), .ldo_three_sleep_voltage_code(l3s),
		.ldo_three_normal_voltage_code(l3n), .buck_one_mode_select(md[0]),
		.buck_two_mode_select(md[1]), .buck_three_mode_select(md[2]), .buck_run(run));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected run bits; a selector past the last pin means the buck stays off
	function automatic logic [2:0] exp_run();
		logic [2:0] r;
		for (int k = 0; k < 3; k++)
			r[k] = (psel[k] < 3'd6) ? (pins[psel[k]] & m[3][k]) : 1'b0;
		return r;
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	// Unmapped places read zero and miss the decode
	task automatic rdchk(input logic [7:0] x);
		logic [7:0] e;
		e = (x >= 8'h99 && x <= 8'h9C) ? 8'(m[x - 8'h99]) : 8'h00;
		h.rd(x, d);
		chk("read", e, d);
		chk("hit", {7'h00, x >= 8'h99 && x <= 8'h9C}, {7'h00, hit});
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (2) @(negedge mclk);
		arst_n = 1'b1;
		for (int i = 0; i < 6; i++) rdchk(8'h98 + 8'(i));
		for (int i = 0; i < 60; i++)
		begin
			void'(nxt());
			a = 8'h99 + 8'(seed[7:0] % 5);
			pins = seed[13:8];
			step_sel = seed[14];
			psel = seed[23:15];
			h.wr(a, seed[31:24]);
			case (a)
				8'h99: m[0] = int'(seed[31:24] & 8'hFE);
				8'h9A: m[1] = int'(seed[31:24]);
				8'h9B: m[2] = int'(seed[31:24]);
				8'h9C: m[3] = int'((seed[31:24] | 8'h20) & 8'h3F);
				default: ;
			endcase
			repeat (8) @(negedge mclk);
			chk("b6", 8'(m[0]), {b6, 1'b0});
			chk("l2", 8'(m[1]), {l2s, l2n});
			chk("l3", 8'(m[2]), {l3s, l3n});
			chk("mode", 8'(m[3] >> 3), {5'h00, md});
			chk("run", {5'h00, exp_run()}, {5'h00, run});
			chk("tab", {6'h00, step_sel ? RVM_STEP_25MV : RVM_STEP_10MV}, {6'h00, tab});
			rdchk(a);
		end
		finish_test();
	end
	initial
	begin
		#20000;
		error_cnt++;
		finish_test();
	end
endmodule
`default_nettype wire
